// ==== rtl/fbppc_pkg.sv ====
// holds constants and types shared by the five-bit port, its checker and its bench
// assumes a single 200 MHz core clock and an active-low asynchronous reset
package fbppc_pkg;

    // ****************************************************************
    // register map, word offsets in bytes
    // ****************************************************************
    localparam logic [3:0] OFS_PORT = 4'h0;
    localparam logic [3:0] OFS_LATCH = 4'h4;
    localparam logic [3:0] OFS_DIR = 4'h8;
    localparam logic [3:0] OFS_SEG = 4'hC;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int PIN_COUNT = 5;
    localparam int BIT_PU_J = 5;
    localparam int BIT_PU_E = 6;
    localparam int BIT_PU_D = 7;
    localparam int BIT_LAT_UNUSED = 5;
    localparam int BIT_OD_SER1 = 6;
    localparam int BIT_OD_SER2 = 7;
    localparam int BIT_OD_CMP1 = 5;
    localparam int BIT_OD_CMP2 = 6;
    localparam int BIT_OD_SYNC = 7;
    localparam int BIT_LCD_SEGMENT_PIN_OUT = 2;
    localparam int PIN_CLK = 1;
    localparam int PIN_DATA = 2;
    localparam int PIN_SEG = 4;

    // ****************************************************************
    // reset values and masks
    // ****************************************************************
    localparam logic [7:0] RST_PORT = 8'hE0;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h1F;
    localparam logic [7:0] RST_SEG = 8'h00;
    localparam logic [7:0] LATCH_MASK = 8'hDF;
    localparam logic [4:0] BIAS_PINS = 5'h0D;

    // ****************************************************************
    // bus handshake states and transceiver carrier
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK = 2'b10
    } fbppc_bus_e;

    typedef struct packed {
        logic active;
        logic sync_mode;
        logic tx_drive;
        logic tx_data;
        logic dt_drive;
        logic dt_data;
    } fbppc_ser_s;

endpackage : fbppc_pkg

// ==== rtl/fbppc_pad.sv ====
// holds the output and read multiplexer of one port pin
// assumes the pin level arrives synchronous to the core clock
module fbppc_pad (
    input wire logic analog_take,
    input wire logic seg_take,
    input wire logic seg_val,
    input wire logic periph_oe,
    input wire logic periph_val,
    input wire logic od_en,
    input wire logic lat_bit,
    input wire logic dir_bit,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic read_val
);

    // ****************************************************************
    // drive priority: bias, segment, peripheral, latch
    // ****************************************************************
    logic drv_val;
    logic drv_en;

    always_comb begin
        drv_val = lat_bit;
        drv_en = ~dir_bit;
        if (periph_oe) begin
            drv_val = periph_val;
            drv_en = 1'b1;
        end
        pin_out = 1'b0;
        pin_oe = 1'b0;
        read_val = pin_in;
        if (analog_take) begin
            read_val = 1'b0;
        end else if (seg_take) begin
            pin_out = seg_val;
            pin_oe = 1'b1;
            read_val = 1'b0;
        end else if (od_en) begin
            // open drain: only a low is driven, a high floats
            pin_oe = drv_en & ~drv_val;
        end else begin
            pin_out = drv_val;
            pin_oe = drv_en;
        end
    end

endmodule // fbppc_pad

// ==== rtl/fbppc_port.sv ====
// holds the five-bit port: registers, Avalon-MM slave and pin muxing
// assumes the transceiver, lcd and capture/compare blocks sit outside
//
// Overview of operation
// - five two-way pins each have a latch bit and a direction bit in separate registers.
// - with transceiver 2 active, latch bit 7 set makes pin 1 open drain, else push-pull.
// - an enabled segment 26 drive takes pin 4 and blocks the port and all else there.
// - lcd bias use of pins 0, 2 and 3 removes port and all other functions from them.
// - a peripheral forcing direction acts only at the pin, the direction register keeps its value.
// - port bits 7 to 5 exist without pins and clearing one enables the d, e or j pull-ups.
// - every reset leaves all these pull-ups disabled.
// - direction bits 7 to 5 and latch bits 7 and 6 select open drain for sync serial, compare 2, compare 1 and transceivers 2 and 1.
// - latch bit 5 is absent, reads zero and ignores writes.
// - transceiver output on pin 1 or pin 2 wins over the port latch on that pin.
// - in synchronous mode with external clock pin 1 is the transceiver clock input when its direction bit is set.
// - on the small package the port j pull-up bit is absent and reads zero.
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
module fbppc_port
    import fbppc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [4:0] pin_in,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe,
    input wire logic small_package,
    input wire fbppc_ser_s ser2,
    output logic serial_receive_in,
    output logic serial_clock_pin,
    input wire logic lcd_bias_enable,
    input wire logic lcd_segment_pin_out,
    output logic port_d_pullup_enable_n,
    output logic port_e_pullup_enable_n,
    output logic port_j_pullup_enable_n,
    output logic serial2_opendrain_sel,
    output logic serial1_opendrain_sel,
    output logic sync_serial_opendrain_sel,
    output logic compare2_opendrain_sel,
    output logic compare1_opendrain_sel
);

    // ****************************************************************
    // bus handshake
    // ****************************************************************
    fbppc_bus_e bus_reg;
    fbppc_bus_e bus_next;
    logic req;
    logic take;
    logic wr_take;

    assign req = avs_read | avs_write;
    // every access costs one wait cycle so read data can come from a flop
    // back to back requests therefore take two cycles each
    assign avs_waitrequest = req & (bus_reg != ST_ACK);
    assign take = req & (bus_reg == ST_ACK);
    assign wr_take = take & avs_write & avs_byteenable[0];

    always_comb begin
        bus_next = bus_reg;
        unique case (bus_reg)
            ST_IDLE: begin
                if (req) begin
                    bus_next = ST_ACK;
                end
            end
            ST_ACK: begin
                bus_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_reg <= ST_IDLE;
        end else begin
            bus_reg <= bus_next;
        end
    end

    // ****************************************************************
    // write strobes, one per register, and a single read load strobe
    // ****************************************************************
    logic wr_port;
    logic wr_latch;
    logic wr_dir;
    logic wr_seg;
    logic rd_load;

    assign wr_port = wr_take & (avs_address == OFS_PORT);
    assign wr_latch = wr_take & (avs_address == OFS_LATCH);
    assign wr_dir = wr_take & (avs_address == OFS_DIR);
    assign wr_seg = wr_take & (avs_address == OFS_SEG);
    // read data is captured in the first cycle of a read and stands through the answer
    assign rd_load = avs_read & (bus_reg == ST_IDLE);

    // ****************************************************************
    // port register: latch bits 4..0 and pull-up controls
    // ****************************************************************
    logic [7:0] port_value_register_reg;
    logic [7:0] latch_register_reg;
    logic [7:0] direction_register_reg;
    logic [7:0] segment_enable_register_reg;
    logic [7:0] wbyte;

    // only the low byte lane carries register data, the upper lanes are ignored
    assign wbyte = avs_writedata[7:0];

    // bits 7 to 5 hold the pull-up controls, bits 4 to 0 go on into the latch
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_value_register_reg <= RST_PORT;
        end else if (wr_port) begin
            port_value_register_reg <= wbyte;
        end
    end

    // ****************************************************************
    // latch register: writes through port or latch address
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_register_reg <= RST_LATCH;
        end else if (wr_latch) begin
            // the mask keeps bit 5 at zero, so it never stores a value
            latch_register_reg <= wbyte & LATCH_MASK;
        end else if (wr_port) begin
            latch_register_reg[4:0] <= wbyte[4:0];
        end
    end

    // ****************************************************************
    // direction register
    // ****************************************************************
    // peripheral overrides never write back here, so read-modify-write is safe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            direction_register_reg <= RST_DIR;
        end else if (wr_dir) begin
            direction_register_reg <= wbyte;
        end
    end

    // ****************************************************************
    // segment enable register
    // ****************************************************************
    // bit 2 is segment 26, the only segment that lands on this port
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            segment_enable_register_reg <= RST_SEG;
        end else if (wr_seg) begin
            segment_enable_register_reg <= wbyte;
        end
    end

    // ****************************************************************
    // pull-up and open-drain outputs
    // ****************************************************************
    logic pu_j_bit;

    // the small package has no j port, so its pull-up is held off
    assign pu_j_bit = port_value_register_reg[BIT_PU_J] | small_package;
    assign port_d_pullup_enable_n = port_value_register_reg[BIT_PU_D];
    assign port_e_pullup_enable_n = port_value_register_reg[BIT_PU_E];
    assign port_j_pullup_enable_n = pu_j_bit;

    // ****************************************************************
    // open-drain selects for the peripherals that own other pins
    // ****************************************************************
    assign serial2_opendrain_sel = latch_register_reg[BIT_OD_SER2];
    assign serial1_opendrain_sel = latch_register_reg[BIT_OD_SER1];
    assign sync_serial_opendrain_sel = direction_register_reg[BIT_OD_SYNC];
    assign compare2_opendrain_sel = direction_register_reg[BIT_OD_CMP2];
    assign compare1_opendrain_sel = direction_register_reg[BIT_OD_CMP1];

    // ****************************************************************
    // per-pin takeover and peripheral drive
    // ****************************************************************
    logic [4:0] analog_take;
    logic [4:0] seg_take;
    logic [4:0] periph_oe;
    logic [4:0] periph_val;
    logic [4:0] od_en;
    logic [4:0] pin_read;

    always_comb begin
        analog_take = 5'h00;
        if (lcd_bias_enable) begin
            // bias and charge-pump pins turn analog, port and peripherals lose them
            analog_take = BIAS_PINS;
        end
    end

    always_comb begin
        seg_take = 5'h00;
        if (segment_enable_register_reg[BIT_LCD_SEGMENT_PIN_OUT]) begin
            seg_take[PIN_SEG] = 1'b1;
        end
    end

    always_comb begin
        periph_oe = 5'h00;
        periph_val = 5'h00;
        od_en = 5'h00;
        if (ser2.active) begin
            // pin 1 carries asynchronous transmit or the synchronous clock
            periph_oe[PIN_CLK] = ser2.tx_drive;
            periph_val[PIN_CLK] = ser2.tx_data;
            od_en[PIN_CLK] = latch_register_reg[BIT_OD_SER2];
            // pin 2 is driven only for synchronous data, receive needs it as input
            if (ser2.sync_mode) begin
                periph_oe[PIN_DATA] = ser2.dt_drive;
                periph_val[PIN_DATA] = ser2.dt_data;
            end
        end
    end

    // each pad resolves its own priority, so the pins never interact
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pad
            fbppc_pad u_pad (
                .analog_take(analog_take[gi]),
                .seg_take(seg_take[gi]),
                .seg_val(lcd_segment_pin_out),
                .periph_oe(periph_oe[gi]),
                .periph_val(periph_val[gi]),
                .od_en(od_en[gi]),
                .lat_bit(latch_register_reg[gi]),
                .dir_bit(direction_register_reg[gi]),
                .pin_in(pin_in[gi]),
                .pin_out(pin_out[gi]),
                .pin_oe(pin_oe[gi]),
                .read_val(pin_read[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // transceiver inputs
    // ****************************************************************
    // receive relies on software leaving pin 2 as input
    assign serial_receive_in = ser2.active & ~analog_take[PIN_DATA] & pin_read[PIN_DATA];
    logic ext_clk_sel;

    // an external clock only while the transceiver is not driving pin 1 itself
    assign ext_clk_sel = ser2.active & ser2.sync_mode & ~ser2.tx_drive
        & direction_register_reg[PIN_CLK];
    assign serial_clock_pin = ext_clk_sel & pin_read[PIN_CLK];

    // ****************************************************************
    // read data
    // ****************************************************************
    logic [7:0] rd_byte;
    logic [7:0] port_read;
    logic pu_j_read;

    // the j pull-up bit is masked on read on the small package, so it reads zero
    assign pu_j_read = pu_j_bit & ~small_package;
    assign port_read = {port_value_register_reg[7:6], pu_j_read, pin_read};

    always_comb begin
        rd_byte = 8'h00;
        unique case (avs_address)
            OFS_PORT: begin
                rd_byte = port_read;
            end
            OFS_LATCH: begin
                rd_byte = latch_register_reg;
            end
            OFS_DIR: begin
                // the stored value, a peripheral override never shows here
                rd_byte = direction_register_reg;
            end
            OFS_SEG: begin
                rd_byte = segment_enable_register_reg;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // ****************************************************************
    // read data register
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (rd_load) begin
            avs_readdata <= {24'h000000, rd_byte};
        end
    end

endmodule // fbppc_port

// ==== verification/fbppc_port_props.sv ====
// checker for the five-bit port, seen only through its top-level ports
// assumes one core clock; shadows the registers from completed bus writes
module fbppc_port_props
    import fbppc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic [4:0] pin_in,
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe,
    input wire logic small_package,
    input wire fbppc_ser_s ser2,
    input wire logic serial_clock_pin,
    input wire logic lcd_bias_enable,
    input wire logic lcd_segment_pin_out,
    input wire logic port_d_pullup_enable_n,
    input wire logic port_e_pullup_enable_n,
    input wire logic port_j_pullup_enable_n,
    input wire logic serial2_opendrain_sel,
    input wire logic serial1_opendrain_sel,
    input wire logic sync_serial_opendrain_sel,
    input wire logic compare2_opendrain_sel,
    input wire logic compare1_opendrain_sel
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // shadow registers and properties
    // ****
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [2:0] pu_reg;
    logic [7:0] lat_reg;
    logic [7:0] dir_reg;
    logic seg_reg;
    logic [4:0] od_sel;
    assign od_sel = {serial2_opendrain_sel, serial1_opendrain_sel, sync_serial_opendrain_sel,
        compare2_opendrain_sel, compare1_opendrain_sel};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pu_reg <= 3'h7;
            lat_reg <= RST_LATCH;
            dir_reg <= RST_DIR;
            seg_reg <= 1'b0;
        end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
            case (avs_address)
                OFS_PORT: begin
                    pu_reg <= avs_writedata[7:5];
                    lat_reg[4:0] <= avs_writedata[4:0];
                end
                OFS_LATCH: lat_reg <= avs_writedata[7:0] & LATCH_MASK;
                OFS_DIR: dir_reg <= avs_writedata[7:0];
                OFS_SEG: seg_reg <= avs_writedata[BIT_LCD_SEGMENT_PIN_OUT];
                default: ;
            endcase
        end
    end
    property p_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    property p_rst_pu;
        $rose(rst_n) |-> {port_d_pullup_enable_n, port_e_pullup_enable_n,
            port_j_pullup_enable_n} == 3'h7;
    endproperty
    property p_pu;
        {port_d_pullup_enable_n, port_e_pullup_enable_n} == pu_reg[2:1];
    endproperty
    property p_small;
        small_package |-> port_j_pullup_enable_n;
    endproperty
    property p_od_sel;
        od_sel == {lat_reg[7:6], dir_reg[7:5]};
    endproperty
    property p_seg;
        seg_reg |-> pin_oe[4] && (pin_out[4] == lcd_segment_pin_out);
    endproperty
    property p_bias;
        lcd_bias_enable |-> (pin_oe & BIAS_PINS) == 5'h00;
    endproperty
    property p_tx;
        ser2.active && ser2.tx_drive && !lat_reg[7] |-> pin_oe[1] && pin_out[1] == ser2.tx_data;
    endproperty
    property p_od;
        ser2.active && ser2.tx_drive && lat_reg[7] |->
            (pin_oe[1] == !ser2.tx_data) && !(pin_oe[1] && pin_out[1]);
    endproperty
    property p_clk;
        ser2.active && ser2.sync_mode && !ser2.tx_drive && dir_reg[PIN_CLK] |->
            serial_clock_pin == pin_in[1];
    endproperty
    property p_gpio;
        !ser2.active && !lcd_bias_enable |->
            pin_oe[3] == !dir_reg[3] && (dir_reg[3] || pin_out[3] == lat_reg[3]);
    endproperty
    a_wait: assert property (p_wait) else $error("wait not one cycle");
    a_rst_pu: assert property (p_rst_pu) else $error("pull-up on after reset");
    a_pu: assert property (p_pu) else $error("pull-up enable wrong");
    a_small: assert property (p_small) else $error("j pull-up on small package");
    a_od_sel: assert property (p_od_sel) else $error("open-drain select wrong");
    a_seg: assert property (p_seg) else $error("segment not on pin 4");
    a_bias: assert property (p_bias) else $error("bias pin driven");
    a_tx: assert property (p_tx) else $error("transmit not on pin 1");
    a_od: assert property (p_od) else $error("pin 1 not open drain");
    a_clk: assert property (p_clk) else $error("clock input wrong");
    a_gpio: assert property (p_gpio) else $error("pin 3 port drive wrong");
    c_seg: cover property (seg_reg && pin_oe[4]);
    c_bias: cover property (lcd_bias_enable);
    c_od: cover property (ser2.active && ser2.tx_drive && lat_reg[7]);
endmodule // fbppc_port_props

bind fbppc_port fbppc_port_props fbppc_port_props_inst (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .small_package(small_package), .ser2(ser2), .serial_clock_pin(serial_clock_pin),
    .lcd_bias_enable(lcd_bias_enable), .lcd_segment_pin_out(lcd_segment_pin_out),
    .port_d_pullup_enable_n(port_d_pullup_enable_n),
    .port_e_pullup_enable_n(port_e_pullup_enable_n),
    .port_j_pullup_enable_n(port_j_pullup_enable_n),
    .serial2_opendrain_sel(serial2_opendrain_sel), .serial1_opendrain_sel(serial1_opendrain_sel),
    .sync_serial_opendrain_sel(sync_serial_opendrain_sel),
    .compare2_opendrain_sel(compare2_opendrain_sel),
    .compare1_opendrain_sel(compare1_opendrain_sel));

// ==== verification/fbppc_pins.sv ====
// board model of the five port pins with external drivers and pull-ups
// assumes the bench sets which pins the outside world drives
module fbppc_pins (
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe,
    input wire logic [4:0] ext_oe,
    input wire logic [4:0] ext_val,
    output logic [4:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // pin resolution
    // ****
    // an undriven pin goes to the pull-up level, never keeps its last value
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe);
endmodule // fbppc_pins

// ==== verification/fbppc_port_tb.sv ====
// self-checking bench for the five-bit port
// assumes the pin model and the bound checker are compiled alongside
module fbppc_port_tb
    import fbppc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // stimulus and checks
    // ****
    typedef struct packed {logic we; logic [3:0] a; logic [7:0] d; logic [7:0] e;} fbppc_row_s;
    fbppc_row_s rows [11] = '{'{1'b0, OFS_PORT, 8'h00, 8'hFF}, '{1'b0, OFS_DIR, 8'h00, 8'h1F},
        '{1'b0, OFS_LATCH, 8'h00, 8'h00}, '{1'b0, OFS_SEG, 8'h00, 8'h00},
        '{1'b1, OFS_DIR, 8'hE0, 8'hE0}, '{1'b1, OFS_LATCH, 8'hFF, 8'hDF},
        '{1'b1, OFS_PORT, 8'h0A, 8'h0A}, '{1'b0, OFS_LATCH, 8'h00, 8'hCA},
        '{1'b1, 4'h2, 8'hFF, 8'h00}, '{1'b1, OFS_SEG, 8'h04, 8'h04}, '{1'b1, OFS_SEG, 8'h00, 8'h00}};
    logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, small_package, bias, seg_val;
    logic rx, sck, pd, pe, pj, s2, s1, ss, c2, c1;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [4:0] pin_in, pin_out, pin_oe, ext_oe, ext_val;
    fbppc_ser_s ser2;
    int error_cnt = 0;
    int checked = 0;
    fbppc_port fbppc_port_inst (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .small_package(small_package),
        .ser2(ser2), .serial_receive_in(rx), .serial_clock_pin(sck), .lcd_bias_enable(bias),
        .lcd_segment_pin_out(seg_val), .port_d_pullup_enable_n(pd), .port_e_pullup_enable_n(pe),
        .port_j_pullup_enable_n(pj), .serial2_opendrain_sel(s2), .serial1_opendrain_sel(s1),
        .sync_serial_opendrain_sel(ss), .compare2_opendrain_sel(c2),
        .compare1_opendrain_sel(c1));
    fbppc_pins fbppc_pins_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_oe(ext_oe),
        .ext_val(ext_val), .pin_in(pin_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (error_cnt == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // waitrequest and read data are sampled at the rising edge, before the design updates
    task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= we;
        avs_read <= !we;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            error_cnt++;
            close_out();
        end
    endtask
    task automatic step;
        @(posedge core_clk);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        {rst_n, avs_read, avs_write, small_package, bias, seg_val} = 6'h00;
        {avs_address, avs_writedata, ext_oe, ext_val, ser2} = '0;
        avs_byteenable = 4'h1;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].we) bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 8'h00);
            chk(rd, {24'h0, rows[i].e});
        end
        small_package <= 1'b1;
        bus(1'b1, OFS_PORT, 8'h2A);
        bus(1'b0, OFS_PORT, 8'h00);
        chk(rd, 32'h0A);
        chk({pd, pe, pj}, 3'h1);
        small_package <= 1'b0;
        bus(1'b1, OFS_DIR, 8'hE6);
        ser2 <= 6'h3E;
        step();
        chk(pin_oe[1], 1'b0);
        ser2.tx_data <= 1'b0;
        step();
        chk({pin_oe[1], pin_out[1]}, 2'h2);
        bus(1'b1, OFS_LATCH, 8'h4A);
        ser2.tx_data <= 1'b1;
        step();
        chk({pin_oe[1], pin_out[1]}, 2'h3);
        chk({s2, s1, ss, c2, c1}, 5'h0F);
        avs_byteenable <= 4'h0;
        bus(1'b1, OFS_DIR, 8'h00);
        avs_byteenable <= 4'h1;
        bus(1'b0, OFS_DIR, 8'h00);
        chk(rd, 32'hE6);
        ser2 <= 6'h30;
        ext_oe <= 5'h06;
        step();
        chk({sck, rx}, 2'h0);
        ext_val <= 5'h06;
        step();
        chk({sck, rx}, 2'h3);
        ser2 <= '0;
        ext_oe <= 5'h00;
        seg_val <= 1'b1;
        bus(1'b1, OFS_SEG, 8'h04);
        bus(1'b0, OFS_PORT, 8'h00);
        chk(rd, 32'h2E);
        bias <= 1'b1;
        bus(1'b0, OFS_PORT, 8'h00);
        chk(rd, 32'h22);
        chk(pin_oe & BIAS_PINS, 5'h00);
        rst_n <= 1'b0;
        step();
        chk({pd, pe, pj}, 3'h7);
        rst_n <= 1'b1;
        bus(1'b0, OFS_DIR, 8'h00);
        chk(rd, {24'h0, RST_DIR});
        close_out();
    end
endmodule // fbppc_port_tb
